//--- hw/gpc_consts.vh
/*
  Constants for the six-bit port with pin-change detection.
  Assumes inclusion by bare name from the design files.
*/
`ifndef GPC_CONSTS_VH
`define GPC_CONSTS_VH

`define GPC_ADDR_W 3
`define GPC_ADDR_PIN 3'h0
`define GPC_ADDR_DIR 3'h1
`define GPC_ADDR_OUT 3'h2
`define GPC_ADDR_MASK 3'h3
`define GPC_ADDR_FLAG 3'h4
`define GPC_ADDR_CTRL 3'h5
`define GPC_ADDR_GIE 3'h6
`define GPC_FLAG_BIT 5
`define GPC_PIE_BIT 5
`define GPC_PUD_BIT 4
`define GPC_MASK_W 6
`define GPC_RST_BYTE 8'h00
`define GPC_RST_PORT 6'h00

`endif

//--- hw/gpc_sync.v
/*
  Pin input synchronizer: half-cycle latch then register.
  Assumes pins are sampled against the single system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpc_consts.vh"

module gpc_sync #(
  parameter W = 6
) (
  input wire clock, // System clock
  input wire reset_n, // Synchronous reset, active low
  input wire [W-1:0] pin_level, // Pad levels
  output reg [W-1:0] pin_sync // Synchronized levels
);
  reg [W-1:0] pin_latch;

  // Holds the level seen while clock was high, as the latch closes
  always @(negedge clock) begin
    pin_latch <= pin_level;
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      pin_sync <= {W{1'b0}};
    end else begin
      pin_sync <= pin_latch;
    end
  end
endmodule // gpc_sync

`default_nettype wire

//--- hw/gpc_pad.v
/*
  Per-pin pad control: direction, output value and pull-up.
  Assumes reset_n arrives directly so pins tri-state without a clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpc_consts.vh"

module gpc_pad #(
  parameter W = 6
) (
  input wire reset_n, // Reset, active low
  input wire [W-1:0] dir, // Direction bits
  input wire [W-1:0] out_value, // Output-value bits
  input wire pullup_disable, // Global pull-up disable
  output wire [W-1:0] pin_out, // Pad output level
  output wire [W-1:0] pin_oe, // Pad drive enable
  output wire [W-1:0] pin_pullup // Pad pull-up enable
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_pad
      assign pin_oe[i] = reset_n & dir[i];
      assign pin_out[i] = out_value[i];
      assign pin_pullup[i] = reset_n & ~dir[i] & out_value[i] & ~pullup_disable;
    end
  endgenerate
endmodule // gpc_pad

`default_nettype wire

//--- hw/gpc_port.v
/*
  Six-bit general-purpose port with pin-change flag.
  Assumes a byte-wide register port with one-cycle read/write strobes,
  and a core that pulses irq_ack when it enters the change routine.
*/
// Overview of operation
// - Masked pin change sets the shared change flag.
// - Vector request only with flag, change enable and global enable set.
// - Flag cleared on routine entry or by writing one.
// - Each mask bit enables change detection on its pin.
// - Mask bits 7 and 6 read zero, writes ignored.
// - Output-value and direction read/write; pin input read-only.
// - Direction one makes output, zero makes input.
// - Input with value one and pull-ups allowed enables pull-up.
// - Global pull-up disable turns off all pull-ups.
// - Output drives the output-value bit.
// - Writing one to pin input toggles output value.
// - Reset tri-states all pins without a clock.
// - Single-bit changes leave other bits untouched.
// - Pin level read through clock-high transparent latch then register.
// - External change visible after half to one and a half cycles.
// - Software output value visible one cycle after write.
// - Alternate functions leave other pins unaffected.
// - Change detection needs the system clock to compare pins and set the flag.
// - Output pins still raise change requests.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_consts.vh"

module gpc_port #(
  parameter W = 6
) (
  input wire clock, // 40 MHz system clock
  input wire reset_n, // Synchronous reset, active low
  input wire [`GPC_ADDR_W-1:0] reg_addr, // Register select
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  input wire [7:0] reg_wdata, // Write data
  input wire [7:0] bit_mask, // Bit-access lanes, all ones for whole byte
  output reg [7:0] reg_rdata, // Read data
  input wire irq_ack, // Change routine entered
  output wire irq_req, // Change vector request
  input wire [W-1:0] pin_in, // Pad input levels
  output wire [W-1:0] pin_out, // Pad output levels
  output wire [W-1:0] pin_oe, // Pad drive enables
  output wire [W-1:0] pin_pullup // Pad pull-up enables
);
  // Unused read bits above the port width
  localparam UPPER_W = 8 - W;

  // Port and change-detection state
  reg [W-1:0] dir_reg;
  reg [W-1:0] out_value_reg;
  reg [W-1:0] change_mask_reg;
  reg change_flag;
  reg change_enable;
  reg global_pullup_disable;
  reg global_irq_enable;
  reg [W-1:0] pin_prev;

  // Next values, settled combinationally
  reg [W-1:0] next_dir_reg;
  reg [W-1:0] next_out_value_reg;
  reg [W-1:0] next_change_mask_reg;
  reg next_change_flag;
  reg next_change_enable;
  reg next_global_pullup_disable;
  reg next_global_irq_enable;
  reg [7:0] next_reg_rdata;

  // Write selects
  reg wr_pin;
  reg wr_dir;
  reg wr_out;
  reg wr_mask;
  reg wr_flag;
  reg wr_ctrl;
  reg wr_gie;

  wire [W-1:0] pin_input_reg;
  wire [W-1:0] wmask;
  wire [W-1:0] wbits;
  wire [W-1:0] pin_changed;
  wire change_seen;
  wire flag_clear;
  wire [7:0] rd_pin;
  wire [7:0] rd_dir;
  wire [7:0] rd_out;
  wire [7:0] rd_mask;
  wire [7:0] rd_flag;
  wire [7:0] rd_ctrl;
  wire [7:0] rd_gie;

  assign wmask = bit_mask[W-1:0];
  assign wbits = reg_wdata[W-1:0];

  // Write strobe decode, one select per register
  always @* begin
    wr_pin = 1'b0;
    wr_dir = 1'b0;
    wr_out = 1'b0;
    wr_mask = 1'b0;
    wr_flag = 1'b0;
    wr_ctrl = 1'b0;
    wr_gie = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        `GPC_ADDR_PIN: begin
          wr_pin = 1'b1;
        end
        `GPC_ADDR_DIR: begin
          wr_dir = 1'b1;
        end
        `GPC_ADDR_OUT: begin
          wr_out = 1'b1;
        end
        `GPC_ADDR_MASK: begin
          wr_mask = 1'b1;
        end
        `GPC_ADDR_FLAG: begin
          wr_flag = 1'b1;
        end
        `GPC_ADDR_CTRL: begin
          wr_ctrl = 1'b1;
        end
        `GPC_ADDR_GIE: begin
          wr_gie = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  assign flag_clear = wr_flag & bit_mask[`GPC_FLAG_BIT] &
                      reg_wdata[`GPC_FLAG_BIT];

  // Read views, unused upper bits tied low
  assign rd_pin = {{UPPER_W{1'b0}}, pin_input_reg};
  assign rd_dir = {{UPPER_W{1'b0}}, dir_reg};
  assign rd_out = {{UPPER_W{1'b0}}, out_value_reg};
  assign rd_mask = {{UPPER_W{1'b0}}, change_mask_reg};
  assign rd_flag = {2'b00, change_flag, 5'h00};
  assign rd_ctrl = {2'b00, change_enable, global_pullup_disable, 4'h0};
  assign rd_gie = {7'h00, global_irq_enable};

  gpc_sync #(.W(W)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .pin_level(pin_in),
    .pin_sync(pin_input_reg)
  );

  // Per-pin decode keeps alternate functions local
  gpc_pad #(.W(W)) u_pad (
    .reset_n(reset_n),
    .dir(dir_reg),
    .out_value(out_value_reg),
    .pullup_disable(global_pullup_disable),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .pin_pullup(pin_pullup)
  );

  // Per-pin masked change, driven pins included
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_change
      assign pin_changed[i] = (pin_in[i] ^ pin_prev[i]) & change_mask_reg[i];
    end
  endgenerate

  assign change_seen = |pin_changed;

  assign irq_req = change_flag & change_enable & global_irq_enable;

  always @(posedge clock) begin
    if (!reset_n) begin
      pin_prev <= `GPC_RST_PORT;
    end else begin
      pin_prev <= pin_in;
    end
  end

  // Direction, bit lanes keep untouched bits
  always @* begin
    next_dir_reg = dir_reg;
    if (wr_dir) begin
      next_dir_reg = (dir_reg & ~wmask) | (wbits & wmask);
    end
  end

  // Output value: lane write or toggle through pin input
  always @* begin
    next_out_value_reg = out_value_reg;
    if (wr_out) begin
      next_out_value_reg = (out_value_reg & ~wmask) | (wbits & wmask);
    end
    if (wr_pin) begin
      next_out_value_reg = out_value_reg ^ (wbits & wmask);
    end
  end

  // Change mask, only the six pin bits exist
  always @* begin
    next_change_mask_reg = change_mask_reg;
    if (wr_mask) begin
      next_change_mask_reg = (change_mask_reg & ~wmask) | (wbits & wmask);
    end
  end

  // Control: change enable and pull-up disable
  always @* begin
    next_change_enable = change_enable;
    next_global_pullup_disable = global_pullup_disable;
    if (wr_ctrl && bit_mask[`GPC_PIE_BIT]) begin
      next_change_enable = reg_wdata[`GPC_PIE_BIT];
    end
    if (wr_ctrl && bit_mask[`GPC_PUD_BIT]) begin
      next_global_pullup_disable = reg_wdata[`GPC_PUD_BIT];
    end
  end

  // Global interrupt enable
  always @* begin
    next_global_irq_enable = global_irq_enable;
    if (wr_gie && bit_mask[0]) begin
      next_global_irq_enable = reg_wdata[0];
    end
  end

  // Set wins over any clear in the same cycle
  always @* begin
    next_change_flag = change_flag;
    if (change_seen) begin
      next_change_flag = 1'b1;
    end else if (irq_ack || flag_clear) begin
      next_change_flag = 1'b0;
    end
  end

  // Read mux, unmapped addresses read zero
  always @* begin
    case (reg_addr)
      `GPC_ADDR_PIN: begin
        next_reg_rdata = rd_pin;
      end
      `GPC_ADDR_DIR: begin
        next_reg_rdata = rd_dir;
      end
      `GPC_ADDR_OUT: begin
        next_reg_rdata = rd_out;
      end
      `GPC_ADDR_MASK: begin
        next_reg_rdata = rd_mask;
      end
      `GPC_ADDR_FLAG: begin
        next_reg_rdata = rd_flag;
      end
      `GPC_ADDR_CTRL: begin
        next_reg_rdata = rd_ctrl;
      end
      `GPC_ADDR_GIE: begin
        next_reg_rdata = rd_gie;
      end
      default: begin
        next_reg_rdata = `GPC_RST_BYTE;
      end
    endcase
  end

  // State registers
  always @(posedge clock) begin
    if (!reset_n) begin
      dir_reg <= `GPC_RST_PORT;
      out_value_reg <= `GPC_RST_PORT;
      change_mask_reg <= `GPC_RST_PORT;
      change_enable <= 1'b0;
      global_pullup_disable <= 1'b0;
      global_irq_enable <= 1'b0;
      change_flag <= 1'b0;
    end else begin
      dir_reg <= next_dir_reg;
      out_value_reg <= next_out_value_reg;
      change_mask_reg <= next_change_mask_reg;
      change_enable <= next_change_enable;
      global_pullup_disable <= next_global_pullup_disable;
      global_irq_enable <= next_global_irq_enable;
      change_flag <= next_change_flag;
    end
  end

  // Read data holds until the next read
  always @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata <= `GPC_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= next_reg_rdata;
    end
  end
endmodule // gpc_port

`default_nettype wire

//--- tb/gpc_pins.sv
/* Pad model. Assumes gpc_port pad outputs. */
`timescale 1ns/1ps
`default_nettype none
module gpc_pins (
  input wire logic [5:0] o, // Port out level
  input wire logic [5:0] e, // Port drive
  input wire logic [5:0] u, // Port pull-up
  input wire logic [5:0] d, // Far drive level
  input wire logic [5:0] x, // Far drive on
  output logic [5:0] p // Pin level
);
  // Floating pin shows inverse of far level
  assign p = (e & o) | (~e & x & d) | (~e & ~x & (u | ~d));
endmodule // gpc_pins
`default_nettype wire

//--- tb/gpc_port_chk.sv
/* Port checker. Assumes bind from bench. */
`timescale 1ns/1ps
`default_nettype none
module gpc_port_chk #(parameter W = 6) (
  input wire logic clock, // Clock
  input wire logic reset_n, // Reset
  input wire logic [2:0] reg_addr, // Address
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_wdata, // Wdata
  input wire logic [7:0] bit_mask, // Lanes
  input wire logic [7:0] reg_rdata, // Rdata
  input wire logic irq_ack, // Ack
  input wire logic irq_req, // Request
  input wire logic [W-1:0] pin_in, // Pins
  input wire logic [W-1:0] pin_out, // Out
  input wire logic [W-1:0] pin_oe, // Drive
  input wire logic [W-1:0] pin_pullup // Pull-up
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_rst; disable iff (1'b0) !reset_n |-> pin_oe == 0 && pin_pullup == 0; endproperty
  a_rst: assert property (p_rst) else $error("pad on in reset");
  property p_pull; (pin_pullup & pin_oe) == 0; endproperty
  a_pull: assert property (p_pull) else $error("pull-up on output");
  property p_tog; reg_wr && reg_addr == 3'h0 |=>
    pin_out == ($past(pin_out) ^ ($past(reg_wdata[5:0]) & $past(bit_mask[5:0]))); endproperty
  a_tog: assert property (p_tog) else $error("toggle wrong");
  property p_out; reg_wr && reg_addr == 3'h2 && bit_mask == 8'hFF |=>
    pin_out == $past(reg_wdata[5:0]); endproperty
  a_out: assert property (p_out) else $error("out value wrong");
  property p_res; reg_rd && reg_addr == 3'h3 |=> reg_rdata[7:6] == 2'h0; endproperty
  a_res: assert property (p_res) else $error("mask top bits set");
  property p_up; reg_rd && reg_addr < 3'h3 |=> reg_rdata[7:6] == 2'h0; endproperty
  a_up: assert property (p_up) else $error("upper bits set");
  property p_ack; $stable(pin_in)[*3] ##0 irq_ack |=> !irq_req; endproperty
  a_ack: assert property (p_ack) else $error("ack kept request");
  property p_sync; $stable(pin_in)[*3] ##0 (reg_rd && reg_addr == 3'h0) |=>
    reg_rdata[5:0] == $past(pin_in); endproperty
  a_sync: assert property (p_sync) else $error("pin read wrong");
  property p_pud; reg_wr && reg_addr == 3'h5 && reg_wdata[4] && bit_mask[4] |=>
    pin_pullup == 0; endproperty
  a_pud: assert property (p_pud) else $error("pull-up not off");
  c_irq: cover property ($rose(irq_req));
  c_tog: cover property (reg_wr && reg_addr == 3'h0);
  c_pull: cover property (pin_pullup != 0);
endmodule // gpc_port_chk
`default_nettype wire

//--- tb/test_gpc_port.sv
/* Bench for gpc_port. Assumes pad model and checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module test_gpc_port;
  logic clock = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, irq_ack = 0;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, bit_mask = 0, reg_rdata;
  logic [5:0] pins, pin_out, pin_oe, pin_pullup, xd = 0, xe = 6'h3F;
  logic irq_req;
  int fail_count = 0, comparisons = 0, a;
  always #12.5 clock = ~clock;
  gpc_port dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .bit_mask(bit_mask), .reg_rdata(reg_rdata),
    .irq_ack(irq_ack), .irq_req(irq_req), .pin_in(pins), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup));
  gpc_pins pm (.o(pin_out), .e(pin_oe), .u(pin_pullup), .d(xd), .x(xe), .p(pins));
  task end_of_test;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [2:0] ad, input logic [7:0] d, input logic [7:0] m);
    reg_addr = ad; reg_wdata = d; bit_mask = m; reg_wr = 1;
    @(negedge clock); reg_wr = 0; @(negedge clock);
  endtask
  task rd(input logic [2:0] ad, input logic [7:0] e);
    reg_addr = ad; reg_rd = 1;
    @(negedge clock); reg_rd = 0; @(negedge clock);
    `CHK(reg_rdata, e);
  endtask
  task wirq(input logic v);
    for (int i = 0; i < 6 && irq_req !== v; i++) @(negedge clock);
    `CHK(irq_req, v);
    if (irq_req !== v) end_of_test;
  endtask
  initial begin
    repeat (10) @(negedge clock);
    reset_n = 1; @(negedge clock);
    for (a = 1; a < 8; a++) rd(a[2:0], 8'h00);
    rd(3'h0, 8'h00);
    wr(3'h1, 8'hFF, 8'hFF); rd(3'h1, 8'h3F);
    wr(3'h3, 8'hFF, 8'hFF); rd(3'h3, 8'h3F);
    wr(3'h1, 8'h00, 8'h01); rd(3'h1, 8'h3E);
    $display("test regs done");
    wr(3'h2, 8'h3F, 8'hFF);
    wr(3'h1, 8'h00, 8'hFF);
    xe <= 6'h00;
    `CHK(pin_pullup, 6'h3F);
    rd(3'h0, 8'h00);
    rd(3'h0, 8'h3F);
    wr(3'h5, 8'h10, 8'hFF); `CHK(pin_pullup, 6'h00);
    wr(3'h1, 8'h3F, 8'hFF);
    wr(3'h2, 8'h05, 8'hFF);
    `CHK(pin_oe, 6'h3F);
    `CHK(pin_out, 6'h05);
    rd(3'h0, 8'h05);
    wr(3'h0, 8'h0F, 8'hFF); `CHK(pin_out, 6'h0A);
    $display("test pads done");
    wr(3'h3, 8'h01, 8'hFF);
    wr(3'h4, 8'h20, 8'hFF);
    wr(3'h5, 8'h20, 8'hFF);
    wr(3'h6, 8'h01, 8'hFF);
    wr(3'h0, 8'h02, 8'hFF);
    repeat (4) @(negedge clock);
    `CHK(irq_req, 1'b0);
    wr(3'h0, 8'h01, 8'hFF); wirq(1'b1);
    rd(3'h4, 8'h20);
    irq_ack = 1;
    @(negedge clock);
    irq_ack = 0;
    @(negedge clock);
    `CHK(irq_req, 1'b0);
    wr(3'h0, 8'h01, 8'hFF); wirq(1'b1);
    wr(3'h4, 8'h20, 8'hFF); wirq(1'b0);
    wr(3'h0, 8'h01, 8'hFF); wirq(1'b1);
    wr(3'h6, 8'h00, 8'hFF); `CHK(irq_req, 1'b0);
    $display("test change done");
    reset_n <= 1'b0;
    #1;
    `CHK(pin_oe, 6'h00);
    $display("test reset done");
    end_of_test;
  end
endmodule // test_gpc_port
bind gpc_port gpc_port_chk #(.W(W)) chk (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .bit_mask(bit_mask),
  .reg_rdata(reg_rdata), .irq_ack(irq_ack), .irq_req(irq_req), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
`default_nettype wire
